// ===== shared/tcm_pkg.sv
// Purpose: Shared constants and types for the TDM connection memory block
// Assumes: 100 MHz system clock, 16 streams of 32 channels each
// Notes:   Host register map sits above the connection memory window
package tcm_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int FILL_TIME_NS  = 50000;

  localparam int NSTREAM = 16;
  localparam int CM_DEPTH = 512;
  localparam int CM_W     = 12;
  localparam int DM_W     = 8;
  localparam int HA_W     = 12;
  localparam int HD_W     = 16;

  // Host register offsets
  localparam logic [11:0] ADDR_CTRL    = 12'h400;
  localparam logic [11:0] ADDR_IMS     = 12'h401;
  localparam logic [11:0] ADDR_RXSTART = 12'h402;
  localparam logic [11:0] ADDR_LEN     = 12'h403;
  localparam logic [11:0] ADDR_ERRCNT  = 12'h404;
  localparam logic [11:0] ADDR_SICR    = 12'h410;

  // Field positions
  localparam int IMS_PAT_LSB = 1;
  localparam int MSG_LSB     = 3;
  localparam int RXS_STR_LSB = 7;

  // Control mode codes in entry bits 2:1
  localparam logic [1:0] MODE_HIZ = 2'h0;
  localparam logic [1:0] MODE_MSG = 2'h1;
  localparam logic [1:0] MODE_BER = 2'h2;

  // Reset and limit values
  localparam logic [15:0] ERR_MAX   = 16'hFFFF;
  localparam logic [14:0] PRBS_SEED = 15'h7FFF;
  localparam logic [7:0]  POS_RST   = 8'hFF;

  typedef struct packed {
    logic [3:0] stream;
    logic [6:0] chan;
    logic       ctl;
  } tcm_route_t;

  typedef struct packed {
    logic run;
    logic clr;
    logic fill_en;
  } tcm_ctrl_t;

  typedef enum logic {FILL_IDLE, FILL_RUN} tcm_fill_state_t;

endpackage

// ===== src/tcm_mem.sv
// Purpose: One write port, two registered read ports
// Assumes: Same clock on all ports
// Notes:   No reset; contents undefined until written
`timescale 1ns/1ps
module tcm_mem #(
  parameter int W  = 8,
  parameter int D  = 512,
  parameter int AW = 9
) (
  // Clock
  input  wire logic          sys_clk_in,
  // Write port
  input  wire logic          we_in,
  input  wire logic [AW-1:0] wa_in,
  input  wire logic [W-1:0]  wd_in,
  // Read ports
  input  wire logic [AW-1:0] ra_a_in,
  output logic      [W-1:0]  qa_out,
  input  wire logic [AW-1:0] ra_b_in,
  output logic      [W-1:0]  qb_out
);

  logic [W-1:0] mem [D];

  always_ff @(posedge sys_clk_in)
  begin
    if (we_in)
    begin
      mem[wa_in] <= wd_in;
    end
    qa_out <= mem[ra_a_in];
    qb_out <= mem[ra_b_in];
  end

endmodule // tcm_mem

// ===== src/tcm_prbs.sv
// Purpose: 2^15-1 sequence generator or self-aligning checker
// Assumes: Polynomial x^15 + x^14 + 1
// Notes:   Checker mode shifts in received bits to lock on
`timescale 1ns/1ps
module tcm_prbs #(
  parameter bit SELF_SYNC = 1'b0
) (
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic sys_rst_in,
  // Stepping
  input  wire logic step_in,
  input  wire logic data_in,
  output logic      bit_out
);

  logic [14:0] lfsr_reg;
  wire         fb = lfsr_reg[14] ^ lfsr_reg[13];

  assign bit_out = fb;

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      lfsr_reg <= tcm_pkg::PRBS_SEED;
    else if (step_in)
      lfsr_reg <= {lfsr_reg[13:0], SELF_SYNC ? data_in : fb}; // [R11] [R22]
  end

  chk_lfsr_alive: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R11]
    SELF_SYNC || lfsr_reg != 15'h0000)
    else $error("generator lfsr reached zero");

endmodule // tcm_prbs

// ===== src/tcm_top.sv
// Purpose: Connection memory, block fill, pattern test and quadrant LSB forcing
// Assumes: Link clock sampled by sys_clk_in; 32 channels per frame per stream
// Notes:   Only the 32-channel frame is supported; host reads answer one cycle later
// Contract
// R01: 512 connection entries of 12 bits, addressed by output stream and channel.
// R02: Bit0 low: bits 7:1 source channel, 11:8 source stream, data switched.
// R03: Bit0 high: bits 2:1 pick high impedance, message or pattern test.
// R04: Message mode sends entry bits 10:3 on the output channel.
// R05: Block fill writes pattern into bits 2:0 of all entries, rest zero.
// R06: Host writes pattern, then sets fill enable, then sets fill start.
// R07: Fill ends within 50 us and start bit clears itself.
// R08: After start self-clears, host clears fill enable.
// R09: Clearing start or enable mid-fill aborts the fill.
// R10: After abort by enable, host also clears start before other work.
// R11: One transmitter and receiver of a 2^15-1 pseudo-random sequence.
// R12: Host marks consecutive transmit channels as pattern test entries.
// R13: Receiver checks length channels from its start stream and channel.
// R14: Error count saturates at FFFF, never wraps.
// R15: Clear bit resets error count; host writes one then zero.
// R16: Run bit starts both ends; stopped transmitter sends all ones.
// R17: Host runs two frames plus loop delay, then clears the count.
// R18: Frame splits into four equal quadrants of consecutive channels.
// R19: Set quadrant enable forces bit 0 of channels in that quadrant.
// R20: Four quadrant enables per each of sixteen input streams.
// R21: Entry writes use data bits 11:0; reads return upper bits zero.
// R22: Receiver aligns local sequence to input, counts each differing bit.
`timescale 1ns/1ps
module tcm_top #(
  parameter int FILL_MAX_CYC = tcm_pkg::FILL_TIME_NS / tcm_pkg::CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        sys_rst_in,
  // Host port
  input  wire logic [11:0] host_addr_in,
  input  wire logic [15:0] host_wdata_in,
  input  wire logic        host_wr_in,
  input  wire logic        host_rd_in,
  output logic      [15:0] host_rdata_out,
  // Serial link
  input  wire logic        link_clk_in,
  input  wire logic        frame_pulse_in,
  input  wire logic [15:0] serial_in_streams_in,
  output logic      [15:0] serial_out_streams_out,
  output logic      [15:0] serial_out_oe_out
);

  // Link sampling
  logic [2:0]  lclk_sync_reg;
  logic [1:0]  fp_sync_reg;
  logic [15:0] din_s1_reg;
  logic [15:0] din_s2_reg;
  logic [7:0]  pos_reg;

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      lclk_sync_reg <= '0;
      fp_sync_reg   <= '0;
      din_s1_reg    <= '0;
      din_s2_reg    <= '0;
    end
    else
    begin
      lclk_sync_reg <= {lclk_sync_reg[1:0], link_clk_in};
      fp_sync_reg   <= {fp_sync_reg[0], frame_pulse_in};
      din_s1_reg    <= serial_in_streams_in;
      din_s2_reg    <= din_s1_reg;
    end
  end

  wire       rise      = lclk_sync_reg[1] & ~lclk_sync_reg[2];
  wire [7:0] pos_now   = fp_sync_reg[1] ? 8'h00 : pos_reg + 8'h01;
  wire [4:0] ch_now    = pos_now[7:3];
  wire       first_bit = pos_now[2:0] == 3'h0;
  wire       prep_bit  = pos_now[2:0] == 3'h3;
  wire       last_bit  = pos_now[2:0] == 3'h7;

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      pos_reg <= tcm_pkg::POS_RST;
    else if (rise)
      pos_reg <= pos_now;
  end

  // Host registers
  tcm_pkg::tcm_ctrl_t ctrl_reg;
  logic               fill_start_reg;
  logic [2:0]         fill_pat_reg;
  logic [10:0]        rx_start_reg;
  logic [8:0]         len_reg;
  logic [15:0]        err_cnt_reg;
  logic [3:0]         qen_reg [16];

  wire cm_hit   = host_addr_in[11:9] == 3'h0;
  wire ctrl_wr  = host_wr_in && host_addr_in == tcm_pkg::ADDR_CTRL;
  wire ims_wr   = host_wr_in && host_addr_in == tcm_pkg::ADDR_IMS;
  wire rxs_wr   = host_wr_in && host_addr_in == tcm_pkg::ADDR_RXSTART;
  wire len_wr   = host_wr_in && host_addr_in == tcm_pkg::ADDR_LEN;
  wire sicr_wr  = host_wr_in && host_addr_in[11:4] == tcm_pkg::ADDR_SICR[11:4];

  // Block fill
  tcm_pkg::tcm_fill_state_t fill_state_reg;
  logic [8:0]               fill_addr_reg;
  logic [12:0]              fill_cyc_reg;

  wire fill_run   = fill_state_reg == tcm_pkg::FILL_RUN;
  wire fill_abort = !ctrl_reg.fill_en || !fill_start_reg;
  wire fill_go    = !fill_run && ctrl_reg.fill_en && fill_start_reg;
  wire fill_we    = fill_run && !fill_abort;
  wire fill_last  = fill_we && fill_addr_reg == 9'h1FF;

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      fill_state_reg <= tcm_pkg::FILL_IDLE;
      fill_addr_reg  <= '0;
      fill_cyc_reg   <= '0;
    end
    else
    begin
      fill_cyc_reg <= fill_run ? fill_cyc_reg + 13'h0001 : 13'h0000;
      case (fill_state_reg)
        tcm_pkg::FILL_IDLE:
        begin
          fill_addr_reg <= '0;
          if (fill_go)
            fill_state_reg <= tcm_pkg::FILL_RUN;
        end
        tcm_pkg::FILL_RUN:
        begin
          fill_addr_reg <= fill_addr_reg + 9'h001;
          if (fill_abort || fill_last)
            fill_state_reg <= tcm_pkg::FILL_IDLE; // [R09]
        end
        default: fill_state_reg <= tcm_pkg::FILL_IDLE;
      endcase
    end
  end

  // Register writes; host write beats the self-clear
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ctrl_reg       <= '0;
      fill_start_reg <= 1'b0;
      fill_pat_reg   <= '0;
      rx_start_reg   <= '0;
      len_reg        <= '0;
    end
    else
    begin
      if (ctrl_wr)
        ctrl_reg <= tcm_pkg::tcm_ctrl_t'(host_wdata_in[2:0]);
      if (ims_wr)
      begin
        fill_start_reg <= host_wdata_in[0];
        fill_pat_reg   <= host_wdata_in[tcm_pkg::IMS_PAT_LSB +: 3];
      end
      else if (fill_last)
        fill_start_reg <= 1'b0; // [R07]
      if (rxs_wr)
        rx_start_reg <= host_wdata_in[10:0];
      if (len_wr)
        len_reg <= host_wdata_in[8:0];
    end
  end

  // Connection memory
  logic [11:0] cm_qa;
  logic [11:0] cm_qb;
  logic [3:0]  rd_idx_reg;
  logic [4:0]  rd_ch_reg;
  logic        rd_busy_reg;

  wire        cm_we = fill_we || (host_wr_in && cm_hit && !fill_run);
  wire [8:0]  cm_wa = fill_we ? fill_addr_reg : host_addr_in[8:0];
  wire [11:0] cm_wd = fill_we ? {9'h000, fill_pat_reg} : host_wdata_in[11:0]; // [R05] [R21]

  tcm_mem #(.W(tcm_pkg::CM_W), .D(tcm_pkg::CM_DEPTH), .AW(9)) u_cmem ( // [R01]
    .sys_clk_in (sys_clk_in),
    .we_in      (cm_we),
    .wa_in      (cm_wa),
    .wd_in      (cm_wd),
    .ra_a_in    (host_addr_in[8:0]),
    .qa_out     (cm_qa),
    .ra_b_in    ({rd_idx_reg, rd_ch_reg}),
    .qb_out     (cm_qb)
  );

  // Data memory write sequencer, one stream per cycle
  logic [7:0] cap_reg [16];
  logic [3:0] wr_idx_reg;
  logic [4:0] cap_ch_reg;
  logic       wr_busy_reg;
  logic [7:0] dm_qb;

  wire [3:0] wr_qen  = qen_reg[wr_idx_reg];
  wire       q_force = wr_qen[cap_ch_reg[4:3]]; // [R18] [R20]
  wire [7:0] dm_wd   = cap_reg[wr_idx_reg] | {7'h00, q_force}; // [R19]

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      wr_busy_reg <= 1'b0;
      wr_idx_reg  <= '0;
      cap_ch_reg  <= '0;
    end
    else if (rise && last_bit)
    begin
      wr_busy_reg <= 1'b1;
      wr_idx_reg  <= '0;
      cap_ch_reg  <= ch_now;
    end
    else if (wr_busy_reg)
    begin
      wr_idx_reg  <= wr_idx_reg + 4'h1;
      wr_busy_reg <= wr_idx_reg != 4'hF;
    end
  end

  // Output preparation pipeline for the next channel
  logic        p1_vld_reg;
  logic [3:0]  p1_s_reg;
  logic        p2_vld_reg;
  logic [3:0]  p2_s_reg;
  logic [11:0] p2_cm_reg;

  tcm_pkg::tcm_route_t route;
  assign route = tcm_pkg::tcm_route_t'(cm_qb);

  tcm_mem #(.W(tcm_pkg::DM_W), .D(tcm_pkg::CM_DEPTH), .AW(9)) u_dmem (
    .sys_clk_in (sys_clk_in),
    .we_in      (wr_busy_reg),
    .wa_in      ({wr_idx_reg, cap_ch_reg}),
    .wd_in      (dm_wd),
    .ra_a_in    (9'h000),
    .qa_out     (),
    .ra_b_in    ({route.stream, route.chan[4:0]}), // [R02]
    .qb_out     (dm_qb)
  );

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rd_busy_reg <= 1'b0;
      rd_idx_reg  <= '0;
      rd_ch_reg   <= '0;
      p1_vld_reg  <= 1'b0;
      p1_s_reg    <= '0;
      p2_vld_reg  <= 1'b0;
      p2_s_reg    <= '0;
      p2_cm_reg   <= '0;
    end
    else
    begin
      if (rise && prep_bit)
      begin
        rd_busy_reg <= 1'b1;
        rd_idx_reg  <= '0;
        rd_ch_reg   <= ch_now + 5'h01;
      end
      else if (rd_busy_reg)
      begin
        rd_idx_reg  <= rd_idx_reg + 4'h1;
        rd_busy_reg <= rd_idx_reg != 4'hF;
      end
      p1_vld_reg <= rd_busy_reg;
      p1_s_reg   <= rd_idx_reg;
      p2_vld_reg <= p1_vld_reg;
      p2_s_reg   <= p1_s_reg;
      p2_cm_reg  <= cm_qb;
    end
  end

  wire [1:0] p2_mode   = p2_cm_reg[2:1];
  wire       comp_ber  = p2_cm_reg[0] && p2_mode == tcm_pkg::MODE_BER; // [R03]
  wire       comp_oe   = !p2_cm_reg[0] || p2_mode == tcm_pkg::MODE_MSG || comp_ber; // [R03]
  wire [7:0] comp_byte = p2_cm_reg[0] ? p2_cm_reg[tcm_pkg::MSG_LSB +: 8] : dm_qb; // [R02] [R04]

  // Pattern transmitter
  logic [15:0] tx_use;
  logic        prbs_tx;
  wire         tx_bit  = ctrl_reg.run ? prbs_tx : 1'b1; // [R16]
  wire         tx_step = rise && ctrl_reg.run && (|tx_use); // [R16]

  tcm_prbs #(.SELF_SYNC(1'b0)) u_tx ( // [R11]
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .step_in    (tx_step),
    .data_in    (1'b0),
    .bit_out    (prbs_tx)
  );

  // Per-stream shift, capture and output registers
  logic [7:0]  in_sh_reg   [16];
  logic [7:0]  out_sh_reg  [16];
  logic [7:0]  nxt_byte_reg[16];
  logic [15:0] nxt_oe_reg;
  logic [15:0] nxt_ber_reg;
  logic [15:0] ber_act_reg;
  logic [15:0] out_bit_reg;
  logic [15:0] oe_reg;

  for (genvar g = 0; g < tcm_pkg::NSTREAM; g++)
  begin : g_str
    wire [7:0] in_full = {in_sh_reg[g][6:0], din_s2_reg[g]};
    wire [7:0] sh_src  = first_bit ? nxt_byte_reg[g] : {out_sh_reg[g][6:0], 1'b0};
    assign tx_use[g] = first_bit ? nxt_ber_reg[g] : ber_act_reg[g];

    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
      if (sys_rst_in)
      begin
        in_sh_reg[g]    <= '0;
        cap_reg[g]      <= '0;
        out_sh_reg[g]   <= '0;
        nxt_byte_reg[g] <= '0;
        nxt_oe_reg[g]   <= 1'b0;
        nxt_ber_reg[g]  <= 1'b0;
        ber_act_reg[g]  <= 1'b0;
        out_bit_reg[g]  <= 1'b1;
        oe_reg[g]       <= 1'b0;
        qen_reg[g]      <= '0;
      end
      else
      begin
        if (rise)
        begin
          in_sh_reg[g]   <= in_full;
          out_sh_reg[g]  <= sh_src;
          out_bit_reg[g] <= tx_use[g] ? tx_bit : sh_src[7]; // [R16]
          if (first_bit)
          begin
            oe_reg[g]      <= nxt_oe_reg[g];
            ber_act_reg[g] <= nxt_ber_reg[g];
          end
        end
        if (rise && last_bit)
          cap_reg[g] <= in_full;
        if (p2_vld_reg && p2_s_reg == 4'(g))
        begin
          nxt_byte_reg[g] <= comp_byte;
          nxt_oe_reg[g]   <= comp_oe;
          nxt_ber_reg[g]  <= comp_ber;
        end
        if (sicr_wr && host_addr_in[3:0] == 4'(g))
          qen_reg[g] <= host_wdata_in[3:0]; // [R20]
      end
    end
  end

  assign serial_out_streams_out = out_bit_reg;
  assign serial_out_oe_out      = oe_reg;

  // Pattern receiver
  logic [11:0] rx_left_reg;
  logic        rx_pred;

  wire [3:0]  rx_stream = rx_start_reg[tcm_pkg::RXS_STR_LSB +: 4];
  wire [7:0]  rx_pos    = {rx_start_reg[4:0], 3'h0};
  wire        rx_bit    = din_s2_reg[rx_stream];
  wire        rx_go     = rise && ctrl_reg.run && pos_now == rx_pos && rx_left_reg == 12'h000 &&
                          len_reg != 9'h000; // [R13]
  wire        rx_cmp    = rise && ctrl_reg.run && (rx_go || rx_left_reg != 12'h000);
  wire        rx_err    = rx_cmp && (rx_bit != rx_pred); // [R22]

  tcm_prbs #(.SELF_SYNC(1'b1)) u_rx ( // [R22]
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .step_in    (rx_cmp),
    .data_in    (rx_bit),
    .bit_out    (rx_pred)
  );

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rx_left_reg <= '0;
      err_cnt_reg <= '0;
    end
    else
    begin
      if (!ctrl_reg.run)
        rx_left_reg <= '0; // [R16]
      else if (rx_go)
        rx_left_reg <= {len_reg, 3'h0} - 12'h001; // [R13]
      else if (rx_cmp)
        rx_left_reg <= rx_left_reg - 12'h001;
      if (ctrl_reg.clr)
        err_cnt_reg <= '0; // [R15]
      else if (rx_err && err_cnt_reg != tcm_pkg::ERR_MAX)
        err_cnt_reg <= err_cnt_reg + 16'h0001; // [R14]
    end
  end

  // Host read path, data valid in the cycle after the strobe
  logic [15:0] rd_data_reg;
  logic        rd_cm_sel_reg;
  logic [15:0] rd_mux;

  always_comb
  begin
    case (host_addr_in)
      tcm_pkg::ADDR_CTRL:    rd_mux = {13'h0000, ctrl_reg};
      tcm_pkg::ADDR_IMS:     rd_mux = {12'h000, fill_pat_reg, fill_start_reg};
      tcm_pkg::ADDR_RXSTART: rd_mux = {5'h00, rx_start_reg};
      tcm_pkg::ADDR_LEN:     rd_mux = {7'h00, len_reg};
      tcm_pkg::ADDR_ERRCNT:  rd_mux = err_cnt_reg;
      default:               rd_mux = sicr_wr || host_addr_in[11:4] == tcm_pkg::ADDR_SICR[11:4] ?
                                      {12'h000, qen_reg[host_addr_in[3:0]]} : 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rd_data_reg   <= '0;
      rd_cm_sel_reg <= 1'b0;
    end
    else
    begin
      rd_data_reg   <= host_rd_in && !cm_hit ? rd_mux : 16'h0000;
      rd_cm_sel_reg <= host_rd_in && cm_hit;
    end
  end

  assign host_rdata_out = rd_cm_sel_reg ? {4'h0, cm_qa} : rd_data_reg; // [R21]

  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  chk_fill_self_clear: assert property (fill_last && !ims_wr |=> !fill_start_reg && !fill_run) // [R07]
    else $error("fill start not cleared at completion");
  chk_fill_time: assert property (fill_cyc_reg < FILL_MAX_CYC) // [R07]
    else $error("block fill ran too long");
  chk_fill_abort: assert property (fill_run && fill_abort |=> !fill_run && $stable(fill_start_reg)) // [R09]
    else $error("fill not aborted");
  chk_fill_pattern: assert property (fill_we |-> cm_we && cm_wd == {9'h000, fill_pat_reg}) // [R05]
    else $error("fill wrote wrong word");
  chk_cnt_saturate: assert property (err_cnt_reg == 16'hFFFF && !ctrl_reg.clr |=> err_cnt_reg == 16'hFFFF) // [R14]
    else $error("error count wrapped");
  chk_cnt_clear: assert property (ctrl_reg.clr |=> err_cnt_reg == 16'h0000) // [R15]
    else $error("error count not cleared");
  chk_cnt_step: assert property (rx_err && !ctrl_reg.clr && err_cnt_reg != 16'hFFFF |=>
    err_cnt_reg == $past(err_cnt_reg) + 16'h0001) // [R22]
    else $error("error not counted");
  chk_tx_idle_ones: assert property (rise && !ctrl_reg.run && tx_use[0] |=> out_bit_reg[0]) // [R16]
    else $error("stopped transmitter not sending ones");
  chk_quad_force: assert property (wr_busy_reg && q_force |-> dm_wd[0]) // [R19]
    else $error("quadrant bit not forced");
  chk_cm_read_upper: assert property (host_rd_in && cm_hit |=> host_rdata_out[15:12] == 4'h0 &&
    host_rdata_out[11:0] == cm_qa) // [R21]
    else $error("entry read returned wrong data");

  cov_fill_done: cover property (fill_last);
  cov_bit_error: cover property (rx_err);
  cov_tx_active: cover property (tx_step);
  cov_msg_mode:  cover property (p2_vld_reg && p2_cm_reg[0] && p2_mode == tcm_pkg::MODE_MSG);

endmodule // tcm_top

// ===== verification/tcm_tdm_peer.sv
// Purpose: Far-end TDM peer: link clock, frame pulse, input streams
// Assumes: 256 bit slots per frame; link clock runs free
// Notes:   Stream 1 returns its own output one frame later
`timescale 1ns/1ps
module tcm_tdm_peer (
  // Control
  input  wire logic        inject_in,
  input  wire logic [15:0] serial_out_in,
  // Link
  output logic             link_clk_out,
  output logic             frame_pulse_out,
  output logic      [15:0] serial_in_out
);
  localparam logic [7:0] FILL_BYTE = 8'h3C;
  logic [7:0] pos;
  logic       bit_now;
  logic       loop_line [256];

  initial
  begin
    link_clk_out = 1'b0;
    frame_pulse_out = 1'b0;
    serial_in_out = 16'hFFFF;
    pos = 8'hFF;
    foreach (loop_line[i]) loop_line[i] = 1'b1;
    forever #80 link_clk_out = ~link_clk_out;
  end

  // Changes mid slot, so the device samples settled bits
  always @(negedge link_clk_out)
  begin
    loop_line[pos] = serial_out_in[1];
    pos = pos + 8'h01;
    bit_now = FILL_BYTE[3'h7 - pos[2:0]];
    frame_pulse_out <= (pos == 8'h00);
    serial_in_out <= {{14{bit_now}}, loop_line[pos] ^ inject_in, bit_now};
  end
endmodule // tcm_tdm_peer

// ===== verification/tcm_top_tb.sv
// Purpose: Self-checking bench for the connection memory block
// Assumes: Link clock 160 ns, 32 channels per frame
// Notes:   Count saturation is left to the design's assertions
`timescale 1ns/1ps
module tcm_top_tb;
  logic        sys_clk_in;
  logic        sys_rst_in;
  logic [11:0] host_addr_in;
  logic [15:0] host_wdata_in;
  logic        host_wr_in;
  logic        host_rd_in;
  logic [15:0] host_rdata_out;
  logic        link_clk;
  logic        frame_pulse;
  logic [15:0] serial_in;
  logic [15:0] serial_out;
  logic [15:0] serial_oe;
  logic        inject;
  logic [15:0] rdata;
  logic [15:0] cap_d [256];
  logic [15:0] cap_oe [256];
  int          fail_count;
  int          check_count;
  int          cycles;

  tcm_top #(.FILL_MAX_CYC(600)) i_dut (
    .sys_clk_in            (sys_clk_in),
    .sys_rst_in            (sys_rst_in),
    .host_addr_in          (host_addr_in),
    .host_wdata_in         (host_wdata_in),
    .host_wr_in            (host_wr_in),
    .host_rd_in            (host_rd_in),
    .host_rdata_out        (host_rdata_out),
    .link_clk_in           (link_clk),
    .frame_pulse_in        (frame_pulse),
    .serial_in_streams_in  (serial_in),
    .serial_out_streams_out(serial_out),
    .serial_out_oe_out     (serial_oe)
  );

  tcm_tdm_peer i_peer (
    .inject_in      (inject),
    .serial_out_in  (serial_out),
    .link_clk_out   (link_clk),
    .frame_pulse_out(frame_pulse),
    .serial_in_out  (serial_in)
  );

  initial
  begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  always @(posedge sys_clk_in)
  begin
    cycles = cycles + 1;
    if (cycles == 90000)
    begin
      fail_count = fail_count + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count = check_count + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    host_addr_in <= a;
    host_wdata_in <= d;
    host_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    host_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge sys_clk_in);
    host_addr_in <= a;
    host_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    host_rd_in <= 1'b0;
    #1 rdata = host_rdata_out;
  endtask

  // One whole frame of outputs, sampled mid slot
  task automatic capture();
    @(posedge frame_pulse);
    for (int p = 0; p < 256; p++)
    begin
      @(posedge link_clk);
      repeat (8) @(posedge sys_clk_in);
      #1;
      cap_d[p] = serial_out;
      cap_oe[p] = serial_oe;
    end
  endtask

  function automatic logic [15:0] chan_byte(input int s, input int c, input bit oe);
    logic [15:0] b;
    b = 16'h0000;
    for (int i = 0; i < 8; i++)
      b[7-i] = oe ? cap_oe[c*8+i][s] : cap_d[c*8+i][s];
    return b;
  endfunction

  task automatic test_regs();
    rd(tcm_pkg::ADDR_CTRL);
    chk(rdata, 16'h0000);
    rd(tcm_pkg::ADDR_ERRCNT);
    chk(rdata, 16'h0000);
    rd(12'h7FF);
    chk(rdata, 16'h0000);
    wr(12'h1FF, 16'hF5A5);
    rd(12'h1FF);
    chk(rdata, 16'h05A5);
    $display("test regs done");
  endtask

  task automatic test_fill();
    int n;
    wr(tcm_pkg::ADDR_IMS, 16'h0002);
    wr(tcm_pkg::ADDR_CTRL, 16'h0001);
    wr(tcm_pkg::ADDR_IMS, 16'h0003);
    n = 0;
    // Two cycles per poll, so 2500 polls is the time limit
    do
    begin
      rd(tcm_pkg::ADDR_IMS);
      n++;
    end while (rdata[0] === 1'b1 && n < 2500);
    chk(rdata, 16'h0002);
    wr(tcm_pkg::ADDR_CTRL, 16'h0000);
    rd(12'h000);
    chk(rdata, 16'h0001);
    rd(12'h1FF);
    chk(rdata, 16'h0001);
    wr(12'h1FF, 16'h0123);
    wr(tcm_pkg::ADDR_IMS, 16'h000E);
    wr(tcm_pkg::ADDR_CTRL, 16'h0001);
    wr(tcm_pkg::ADDR_IMS, 16'h000F);
    wr(tcm_pkg::ADDR_CTRL, 16'h0000);
    repeat (600) @(posedge sys_clk_in);
    rd(12'h1FF);
    chk(rdata, 16'h0123);
    wr(tcm_pkg::ADDR_IMS, 16'h0000);
    $display("test fill done");
  endtask

  task automatic test_route();
    wr(12'h045, 16'h052B);
    wr(12'h069, 16'h0012);
    wr(12'h061, 16'h0002);
    wr(12'h024, 16'h0005);
    wr(12'h025, 16'h0005);
    wr(tcm_pkg::ADDR_SICR, 16'h0002);
    wait_frames(3);
    capture();
    chk(chan_byte(2, 5, 0), 16'h00A5);
    chk(chan_byte(2, 5, 1), 16'h00FF);
    chk(chan_byte(2, 6, 1), 16'h0000);
    chk(chan_byte(3, 9, 0), 16'h003D);
    chk(chan_byte(3, 1, 0), 16'h003C);
    chk(chan_byte(1, 4, 0), 16'h00FF);
    chk(chan_byte(1, 5, 1), 16'h00FF);
    $display("test route done");
  endtask

  task automatic wait_frames(input int n);
    repeat (n) @(posedge frame_pulse);
  endtask

  task automatic test_ber();
    wr(tcm_pkg::ADDR_RXSTART, 16'h0084);
    wr(tcm_pkg::ADDR_LEN, 16'h0002);
    wr(tcm_pkg::ADDR_CTRL, 16'h0004);
    wait_frames(3);
    wr(tcm_pkg::ADDR_CTRL, 16'h0006);
    wr(tcm_pkg::ADDR_CTRL, 16'h0004);
    capture();
    chk(16'(chan_byte(1, 4, 0) == 16'h00FF && chan_byte(1, 5, 0) == 16'h00FF), 16'h0000);
    wait_frames(1);
    rd(tcm_pkg::ADDR_ERRCNT);
    chk(rdata, 16'h0000);
    inject = 1'b1;
    wait_frames(1);
    inject = 1'b0;
    wait_frames(1);
    rd(tcm_pkg::ADDR_ERRCNT);
    chk(16'(rdata != 16'h0000), 16'h0001);
    wr(tcm_pkg::ADDR_CTRL, 16'h0006);
    rd(tcm_pkg::ADDR_ERRCNT);
    chk(rdata, 16'h0000);
    wr(tcm_pkg::ADDR_CTRL, 16'h0000);
    $display("test ber done");
  endtask

  initial
  begin
    sys_rst_in = 1'b1;
    host_addr_in = 12'h000;
    host_wdata_in = 16'h0000;
    host_wr_in = 1'b0;
    host_rd_in = 1'b0;
    inject = 1'b0;
    fail_count = 0;
    check_count = 0;
    cycles = 0;
    repeat (5) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    test_regs();
    test_fill();
    test_route();
    test_ber();
    stop_test();
  end
endmodule // tcm_top_tb
